// [hw/rwp_pkg.sv]
// constants, register map and state type of the reset, wake-up and port block
package rwp_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ     = 40;
	localparam int RST_TIME_US = 18000;
	localparam int RST_CYC     = RST_TIME_US * CLK_MHZ;
	localparam int WDT_TIME_US = 18000;
	localparam int WDT_CYC     = WDT_TIME_US * CLK_MHZ;
	localparam int CNT_W       = 20;

	// ****************************************
	// register indices, byte address is index times four
	// ****************************************
	localparam logic [7:0] IX_STATUS = 8'h03;
	localparam logic [7:0] IX_PORT5  = 8'h05;
	localparam logic [7:0] IX_PORT6  = 8'h06;
	localparam logic [7:0] IX_IFLAG  = 8'h0f;
	localparam logic [7:0] IX_TIMER_CONTROL_REG   = 8'h10;
	localparam logic [7:0] IX_DIR5   = 8'h15;
	localparam logic [7:0] IX_DIR6   = 8'h16;
	localparam logic [7:0] IX_PDN    = 8'h1b;
	localparam logic [7:0] IX_OD     = 8'h1c;
	localparam logic [7:0] IX_PH     = 8'h1d;
	localparam logic [7:0] IX_WDC    = 8'h1e;
	localparam logic [7:0] IX_IMASK  = 8'h1f;
	localparam logic [7:0] IX_CMD    = 8'h20;

	// ****************************************
	// reset values and fixed bits
	// ****************************************
	localparam logic [7:0] TIMER_CONTROL_REG_RST  = 8'hbf;
	localparam logic [7:0] ONES_RST  = 8'hff;
	localparam logic [7:0] ZERO_RST  = 8'h00;
	localparam logic [7:0] WDC_RST   = 8'h80;
	localparam logic [7:0] WDC_MASK  = 8'hc0;
	localparam logic [7:0] PH_FIX    = 8'h08;
	localparam logic [4:0] IMASK_FIX = 5'h1f;
	localparam logic [7:0] ST_SW     = 8'he7;
	localparam logic [7:0] ST_RST    = 8'h18;

	// ****************************************
	// field positions
	// ****************************************
	localparam int TIMER_CONTROL_REG_PAB  = 3;
	localparam int WDC_WATCHDOG_ENABLE  = 7;
	localparam int WDC_EIS   = 6;
	localparam int ST_RSTF   = 7;
	localparam int ST_TO     = 4;
	localparam int ST_PD     = 3;
	localparam int IRQ_EX    = 2;
	localparam int IRQ_IC    = 1;
	localparam int IRQ_TC    = 0;
	localparam int CMD_SLEEP = 0;
	localparam int CMD_WATCHDOG_CLEAR_INSTR  = 1;
	localparam int CMD_ENI   = 2;
	localparam int CMD_GLOBAL_IRQ_OFF_INSTR  = 3;
	localparam int P6_INONLY = 3;

	typedef enum logic [1:0] {
		RWP_HOLD  = 2'b00,
		RWP_RUN   = 2'b01,
		RWP_SLEEP = 2'b10
	} rwp_state_t;

endpackage

// [hw/rwp_top.sv]
// reset sequencer, sleep and wake-up control, port 5 and port 6 logic with bus slave
module rwp_top #(
	parameter int RST_CYCLES = rwp_pkg::RST_CYC,
	parameter int WDT_CYCLES = rwp_pkg::WDT_CYC
) (
	// clock and power-on reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// reset sources and timer event
	input  wire logic        ext_reset_n,
	input  wire logic        lvd_det,
	input  wire logic        tcc_ovf,
	// core control
	output logic             core_reset,
	output logic             core_sleep,
	output logic             core_vector,
	output logic             core_resume,
	output logic             osc_en,
	// port 5 pins
	input  wire logic [3:0]  p5_in,
	output logic [3:0]       p5_out,
	output logic [3:0]       p5_oe,
	output logic [2:0]       p5_pd,
	// port 6 pins
	input  wire logic [7:0]  p6_in,
	output logic [7:0]       p6_out,
	output logic [7:0]       p6_oe,
	output logic [7:0]       p6_pu,
	output logic [2:0]       p6_pd
);

	// ****************************************
	// state and registers
	// ****************************************
	rwp_pkg::rwp_state_t     state_r;
	logic [rwp_pkg::CNT_W-1:0] hold_cnt_r;
	logic [rwp_pkg::CNT_W-1:0] wdt_cnt_r;
	logic [7:0]              pre_r;
	logic                    dp_wr_r;
	logic [7:0]              dp_ix_r;
	logic [7:0]              rd_nxt;
	logic [7:0]              st_r;
	logic [7:0]              timer_control_reg_r;
	logic [7:0]              pdn_r;
	logic [7:0]              od_r;
	logic [7:0]              ph_r;
	logic [7:0]              wdc_r;
	logic [2:0]              imask_r;
	logic [2:0]              iflag_r;
	logic [3:0]              dir5_r;
	logic [7:0]              dir6_r;
	logic [3:0]              dat5_r;
	logic [7:0]              dat6_r;
	logic [7:0]              p6_snap_r;
	logic                    p60_q_r;
	logic                    gie_r;

	logic       take;
	logic       wr_en;
	logic [7:0] wd;
	logic       running;
	logic       hold;
	logic       sleep_go;
	logic       watchdog_clear_instr_go;
	logic       watchdog_enable;
	logic       pab;
	logic [7:0] ps_mask;
	logic       wdt_tick;
	logic       wdt_to;
	logic       rst_evt;
	logic       wake_ic;
	logic [2:0] irq_set;
	logic       vec_go;

	assign take     = hsel & htrans[1] & hready;
	assign wr_en    = dp_wr_r;
	assign wd       = hwdata[7:0];
	assign running  = state_r == rwp_pkg::RWP_RUN;
	assign hold     = state_r == rwp_pkg::RWP_HOLD;
	assign sleep_go = wr_en & (dp_ix_r == rwp_pkg::IX_CMD) & wd[rwp_pkg::CMD_SLEEP] & running;
	assign watchdog_clear_instr_go  = wr_en & (dp_ix_r == rwp_pkg::IX_CMD) & wd[rwp_pkg::CMD_WATCHDOG_CLEAR_INSTR] & running;
	assign watchdog_enable     = wdc_r[rwp_pkg::WDC_WATCHDOG_ENABLE];
	assign pab      = timer_control_reg_r[rwp_pkg::TIMER_CONTROL_REG_PAB];
	assign ps_mask  = 8'(8'hff >> (4'h8 - {1'b0, timer_control_reg_r[2:0]}));
	assign wdt_tick = ~hold & (~pab | ((pre_r & ps_mask) == ps_mask));
	assign wdt_to   = watchdog_enable & wdt_tick & (wdt_cnt_r == rwp_pkg::CNT_W'(WDT_CYCLES - 1));
	assign rst_evt  = ~ext_reset_n | lvd_det | wdt_to;
	// only the change flag or a reset event can end sleep; timer and external flags cannot
	assign wake_ic  = (state_r == rwp_pkg::RWP_SLEEP) & iflag_r[rwp_pkg::IRQ_IC]
		& imask_r[rwp_pkg::IRQ_IC];
	assign irq_set  = {
		wdc_r[rwp_pkg::WDC_EIS] & p60_q_r & ~p6_in[0],
		p6_in != p6_snap_r,
		tcc_ovf
	};
	assign vec_go   = gie_r & ((running & |(iflag_r & imask_r)) | wake_ic);

	// ****************************************
	// reset stretch and sleep sequencing
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r    <= rwp_pkg::RWP_HOLD;
			hold_cnt_r <= '0;
		end
		else if (rst_evt)
		begin
			state_r    <= rwp_pkg::RWP_HOLD;
			hold_cnt_r <= '0;
		end
		else
		begin
			case (state_r)
				rwp_pkg::RWP_HOLD:
				begin
					if (hold_cnt_r == rwp_pkg::CNT_W'(RST_CYCLES - 1))
						state_r <= rwp_pkg::RWP_RUN;
					else
						hold_cnt_r <= hold_cnt_r + 1'b1;
				end
				rwp_pkg::RWP_RUN:
				begin
					if (sleep_go)
						state_r <= rwp_pkg::RWP_SLEEP;
				end
				rwp_pkg::RWP_SLEEP:
				begin
					if (wake_ic)
						state_r <= rwp_pkg::RWP_RUN;
				end
				default:
					state_r <= rwp_pkg::RWP_HOLD;
			endcase
		end
	end

	// ****************************************
	// watchdog and prescaler
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			pre_r <= '0;
		else if (rst_evt | (pab & (watchdog_clear_instr_go | sleep_go)))
			pre_r <= '0;
		else if (~hold)
			pre_r <= pre_r + 1'b1;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			wdt_cnt_r <= '0;
		else if (rst_evt | watchdog_clear_instr_go | sleep_go | ~watchdog_enable)
			wdt_cnt_r <= '0;
		else if (wdt_tick)
			wdt_cnt_r <= wdt_cnt_r + 1'b1;
	end

	// ****************************************
	// bus slave
	// ****************************************
	always_comb
	begin
		case (haddr[9:2])
			rwp_pkg::IX_STATUS: rd_nxt = st_r;
			rwp_pkg::IX_PORT5:  rd_nxt = {4'h0, p5_in};
			rwp_pkg::IX_PORT6:  rd_nxt = p6_in;
			rwp_pkg::IX_IFLAG:  rd_nxt = {5'h00, iflag_r};
			rwp_pkg::IX_TIMER_CONTROL_REG:   rd_nxt = timer_control_reg_r;
			rwp_pkg::IX_DIR5:   rd_nxt = {4'h0, dir5_r};
			rwp_pkg::IX_DIR6:   rd_nxt = dir6_r;
			rwp_pkg::IX_PDN:    rd_nxt = pdn_r;
			rwp_pkg::IX_OD:     rd_nxt = od_r;
			rwp_pkg::IX_PH:     rd_nxt = ph_r | rwp_pkg::PH_FIX;
			rwp_pkg::IX_WDC:    rd_nxt = wdc_r & rwp_pkg::WDC_MASK;
			rwp_pkg::IX_IMASK:  rd_nxt = {rwp_pkg::IMASK_FIX, imask_r};
			rwp_pkg::IX_CMD:    rd_nxt = {5'h00, state_r, gie_r};
			default:            rd_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			dp_wr_r   <= 1'b0;
			dp_ix_r   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			dp_wr_r <= take & hwrite;
			if (take)
				dp_ix_r <= haddr[9:2];
			if (take & ~hwrite)
				hrdata <= {24'h00_0000, rd_nxt};
		end
	end

	// ****************************************
	// port 6 snapshot and edge history
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			p6_snap_r <= rwp_pkg::ONES_RST;
			p60_q_r   <= 1'b1;
		end
		else
		begin
			p60_q_r <= p6_in[0];
			if (take & ~hwrite & (haddr[9:2] == rwp_pkg::IX_PORT6))
				p6_snap_r <= p6_in;
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			timer_control_reg_r  <= rwp_pkg::TIMER_CONTROL_REG_RST;
			pdn_r   <= rwp_pkg::ONES_RST;
			od_r    <= rwp_pkg::ZERO_RST;
			ph_r    <= rwp_pkg::ONES_RST;
			wdc_r   <= rwp_pkg::WDC_RST;
			imask_r <= 3'h0;
			dir5_r  <= 4'hf;
			dir6_r  <= rwp_pkg::ONES_RST;
		end
		else if (rst_evt)
		begin
			timer_control_reg_r  <= rwp_pkg::TIMER_CONTROL_REG_RST;
			pdn_r   <= rwp_pkg::ONES_RST;
			od_r    <= rwp_pkg::ZERO_RST;
			ph_r    <= rwp_pkg::ONES_RST;
			wdc_r   <= rwp_pkg::WDC_RST;
			imask_r <= 3'h0;
			dir5_r  <= 4'hf;
			dir6_r  <= rwp_pkg::ONES_RST;
		end
		else
		begin
			if (wr_en & (dp_ix_r == rwp_pkg::IX_TIMER_CONTROL_REG))
				timer_control_reg_r <= wd;
			if (wr_en & (dp_ix_r == rwp_pkg::IX_PDN))
				pdn_r <= wd;
			if (wr_en & (dp_ix_r == rwp_pkg::IX_OD))
				od_r <= wd;
			if (wr_en & (dp_ix_r == rwp_pkg::IX_PH))
				ph_r <= wd;
			if (wake_ic)
				wdc_r[rwp_pkg::WDC_WATCHDOG_ENABLE] <= 1'b1;
			else if (wr_en & (dp_ix_r == rwp_pkg::IX_WDC))
				wdc_r <= wd & rwp_pkg::WDC_MASK;
			if (wr_en & (dp_ix_r == rwp_pkg::IX_IMASK))
				imask_r <= wd[2:0];
			if (wr_en & (dp_ix_r == rwp_pkg::IX_DIR5))
				dir5_r <= wd[3:0];
			if (wr_en & (dp_ix_r == rwp_pkg::IX_DIR6))
				dir6_r <= wd;
		end
	end

	// port data keep their value through later resets
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			dat5_r <= 4'hf;
			dat6_r <= rwp_pkg::ONES_RST;
		end
		else
		begin
			if (wr_en & (dp_ix_r == rwp_pkg::IX_PORT5))
				dat5_r <= wd[3:0];
			if (wr_en & (dp_ix_r == rwp_pkg::IX_PORT6))
				dat6_r <= wd;
		end
	end

	// ****************************************
	// interrupt flags and global enable
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			iflag_r <= 3'h0;
		else if (rst_evt)
			iflag_r <= 3'h0;
		else if (wr_en & (dp_ix_r == rwp_pkg::IX_IFLAG))
			iflag_r <= wd[2:0] | irq_set;
		else
			iflag_r <= iflag_r | irq_set;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			gie_r <= 1'b0;
		else if (rst_evt | vec_go)
			gie_r <= 1'b0;
		else if (wr_en & (dp_ix_r == rwp_pkg::IX_CMD) & running & wd[rwp_pkg::CMD_ENI])
			gie_r <= 1'b1;
		else if (wr_en & (dp_ix_r == rwp_pkg::IX_CMD) & running & wd[rwp_pkg::CMD_GLOBAL_IRQ_OFF_INSTR])
			gie_r <= 1'b0;
	end

	// ****************************************
	// status register
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			st_r <= rwp_pkg::ST_RST;
		else
		begin
			if (wr_en & (dp_ix_r == rwp_pkg::IX_STATUS))
				st_r <= (st_r & ~rwp_pkg::ST_SW) | (wd & rwp_pkg::ST_SW);
			if (rst_evt)
				st_r[rwp_pkg::ST_RSTF] <= 1'b0;
			if (wdt_to)
				st_r[rwp_pkg::ST_TO] <= 1'b0;
			else if (watchdog_clear_instr_go | sleep_go)
				st_r[rwp_pkg::ST_TO] <= 1'b1;
			if (watchdog_clear_instr_go)
				st_r[rwp_pkg::ST_PD] <= 1'b1;
			else if (sleep_go)
				st_r[rwp_pkg::ST_PD] <= 1'b0;
			if (wake_ic)
				st_r[rwp_pkg::ST_RSTF] <= 1'b1;
		end
	end

	// ****************************************
	// core control outputs
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			core_reset  <= 1'b1;
			core_sleep  <= 1'b0;
			core_vector <= 1'b0;
			core_resume <= 1'b0;
			osc_en      <= 1'b1;
		end
		else
		begin
			core_reset  <= rst_evt | hold;
			core_sleep  <= state_r == rwp_pkg::RWP_SLEEP;
			core_vector <= vec_go;
			core_resume <= wake_ic & ~gie_r;
			osc_en      <= state_r != rwp_pkg::RWP_SLEEP;
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			p5_out <= 4'hf;
			p5_oe  <= 4'h0;
			p5_pd  <= 3'h0;
			p6_pd  <= 3'h0;
		end
		else
		begin
			p5_out <= dat5_r;
			p5_oe  <= ~dir5_r & {4{~hold}};
			p5_pd  <= ~pdn_r[2:0];
			p6_pd  <= ~pdn_r[6:4];
		end
	end

	for (genvar i = 0; i < 8; i++)
	begin : g_p6
		localparam logic HAS_CTL = (i != rwp_pkg::P6_INONLY);
		always_ff @(posedge clk_sys or negedge resetn)
		begin
			if (!resetn)
			begin
				p6_out[i] <= 1'b1;
				p6_oe[i]  <= 1'b0;
				p6_pu[i]  <= 1'b0;
			end
			else
			begin
				p6_out[i] <= dat6_r[i];
				p6_oe[i]  <= HAS_CTL & ~hold & ~dir6_r[i] & ~(od_r[i] & dat6_r[i]);
				p6_pu[i]  <= HAS_CTL & ~ph_r[i];
			end
		end
	end

endmodule

// [verif/rwp_asserts.sv]
// concurrent checks on the ports of the reset, wake-up and port block
module rwp_asserts #(
	parameter int RST_CYCLES = 20,
	parameter int WDT_CYCLES = 50
) (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       resetn,
	// reset events
	input wire logic       ext_reset_n,
	input wire logic       lvd_det,
	// core control
	input wire logic       core_reset,
	input wire logic       core_sleep,
	input wire logic       core_vector,
	input wire logic       core_resume,
	input wire logic       osc_en,
	// pins
	input wire logic [3:0] p5_oe,
	input wire logic [7:0] p6_oe,
	input wire logic [7:0] p6_pu
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	int hold_n_r;
	int calm_n_r;

	// cycles core has been held, and cycles since the last wake pulse
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			hold_n_r <= 0;
		else if (!core_reset)
			hold_n_r <= 0;
		else if (hold_n_r < RST_CYCLES)
			hold_n_r <= hold_n_r + 1;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			calm_n_r <= 15;
		else if (core_vector || core_resume)
			calm_n_r <= 0;
		else if (calm_n_r < 15)
			calm_n_r <= calm_n_r + 1;
	end

	sequence s_wake;
		core_vector || core_resume;
	endsequence

	hold_stretch_a: assert property ($fell(core_reset) |-> hold_n_r >= RST_CYCLES - 1)
		else $error("reset stretch too short");
	ext_reset_a: assert property (!ext_reset_n |-> ##[1:2] core_reset)
		else $error("reset pin did not hold the core");
	lvd_reset_a: assert property (lvd_det |-> ##[1:2] core_reset)
		else $error("low voltage did not hold the core");
	osc_hold_a: assert property (core_reset [*3] |-> osc_en)
		else $error("oscillator stopped during reset");
	pins_float_a: assert property (core_reset [*2] |-> p5_oe == 4'h0 && p6_oe == 8'h00)
		else $error("pin driven during reset");
	input_only_a: assert property (p6_oe[3] == 1'h0 && p6_pu[3] == 1'h0)
		else $error("input-only pin driven or pulled");
	sleep_osc_a: assert property (core_sleep [*2] |-> !osc_en)
		else $error("oscillator running in sleep");
	one_pulse_a: assert property (s_wake |-> !(core_vector && core_resume) && !core_reset)
		else $error("wake pulses collide");
	wake_run_a: assert property (s_wake |-> ##[0:2] !core_sleep)
		else $error("wake pulse without leaving sleep");
	resume_sleep_a: assert property (core_resume |-> $past(core_sleep))
		else $error("resume pulse while running");
	sleep_exit_a: assert property ($fell(core_sleep) |-> s_wake or calm_n_r < 3 or ##[0:1] core_reset)
		else $error("sleep left without cause");
endmodule

bind rwp_top rwp_asserts #(
	.RST_CYCLES(RST_CYCLES),
	.WDT_CYCLES(WDT_CYCLES)
) chk_u (
	.clk_sys(clk_sys), .resetn(resetn), .ext_reset_n(ext_reset_n), .lvd_det(lvd_det),
	.core_reset(core_reset), .core_sleep(core_sleep), .core_vector(core_vector),
	.core_resume(core_resume), .osc_en(osc_en), .p5_oe(p5_oe), .p6_oe(p6_oe), .p6_pu(p6_pu)
);

// [verif/rwp_pins.sv]
// board model of the port 5 and port 6 pins
module rwp_pins (
	// clock
	input wire logic       clk_sys,
	// device side
	input wire logic [3:0] p5_out,
	input wire logic [3:0] p5_oe,
	input wire logic [2:0] p5_pd,
	input wire logic [7:0] p6_out,
	input wire logic [7:0] p6_oe,
	// board drive on port 6
	input wire logic [7:0] p6_drv,
	// levels seen by the device
	output logic [3:0]     p5_in,
	output logic [7:0]     p6_in
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] p5_last_r = 4'h0;
	logic [3:0] p5_dn;

	assign p5_dn = {1'h0, p5_pd};

	// a floating port 5 pin flips every cycle
	always @(posedge clk_sys)
		p5_last_r <= p5_in;

	always_comb
	begin
		for (int i = 0; i < 4; i++)
			p5_in[i] = p5_oe[i] ? p5_out[i] : (p5_dn[i] ? 1'h0 : ~p5_last_r[i]);
		for (int i = 0; i < 8; i++)
			p6_in[i] = p6_oe[i] ? p6_out[i] : p6_drv[i];
	end
endmodule

// [verif/reset_wakeup_port_change_bench.sv]
// self-checking bench of the reset, wake-up and port block
module reset_wakeup_port_change_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RC = 20;
	localparam int WC = 50;

	logic        clk_sys = 1'h0;
	logic        resetn = 1'h0;
	logic        hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        ext_reset_n = 1'h1;
	logic        lvd_det = 1'h0;
	logic        tcc_ovf = 1'h0;
	logic [7:0]  p6_drv = 8'hff;
	logic        hreadyout, hresp, core_reset, core_sleep, core_vector, core_resume, osc_en;
	logic [31:0] hrdata;
	logic [3:0]  p5_in, p5_out, p5_oe, s;
	logic [2:0]  p5_pd, p6_pd;
	logic [7:0]  p6_in, p6_out, p6_oe, p6_pu;
	int          fail_count = 0;
	int          tests_run = 0;
	int          cyc = 0;
	logic [7:0]  ix_t [8] = '{rwp_pkg::IX_STATUS, rwp_pkg::IX_TIMER_CONTROL_REG, rwp_pkg::IX_PDN,
		rwp_pkg::IX_OD, rwp_pkg::IX_PH, rwp_pkg::IX_WDC, rwp_pkg::IX_IFLAG, rwp_pkg::IX_IMASK};
	logic [7:0]  rv_t [8] = '{8'h18, 8'hbf, 8'hff, 8'h00, 8'hff, 8'h80, 8'h00, 8'hf8};

	always #12.5 clk_sys = ~clk_sys;

	rwp_top #(.RST_CYCLES(RC), .WDT_CYCLES(WC)) dut_u (
		.clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_reset_n, .lvd_det, .tcc_ovf,
		.core_reset, .core_sleep, .core_vector, .core_resume, .osc_en,
		.p5_in, .p5_out, .p5_oe, .p5_pd, .p6_in, .p6_out, .p6_oe, .p6_pu, .p6_pd
	);

	rwp_pins pins_u (
		.clk_sys, .p5_out, .p5_oe, .p5_pd, .p6_out, .p6_oe, .p6_drv, .p5_in, .p6_in
	);

	// ************
	// tasks
	// ************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic [7:0] ix, input logic wr, input logic [7:0] wd,
		output logic [31:0] rd);
		@(posedge clk_sys);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {22'h0, ix, 2'h0};
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge clk_sys); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] ix, input logic [7:0] wd);
		logic [31:0] d;
		xfer(ix, 1'h1, wd, d);
	endtask

	task automatic rd_chk(input logic [7:0] ix, input logic [31:0] exp);
		logic [31:0] d;
		xfer(ix, 1'h0, 8'h00, d);
		chk(d, exp);
	endtask

	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	// collects {reset, vector, resume, running} over n cycles
	task automatic watch(input int n, output logic [3:0] seen);
		seen = 4'h0;
		repeat (n)
		begin
			#1;
			seen = seen | {core_reset, core_vector, core_resume, !core_sleep};
			@(posedge clk_sys);
		end
	endtask

	task automatic tick_timer();
		@(posedge clk_sys);
		tcc_ovf <= 1'h1;
		@(posedge clk_sys);
		tcc_ovf <= 1'h0;
	endtask

	task automatic pins_cfg(input logic [7:0] dir, input logic [7:0] pull, input logic [7:0] od);
		wr(rwp_pkg::IX_DIR5, dir);
		wr(rwp_pkg::IX_DIR6, dir);
		wr(rwp_pkg::IX_PH, pull);
		wr(rwp_pkg::IX_PDN, pull);
		wr(rwp_pkg::IX_OD, od);
		settle();
	endtask

	// software preparation for a port-change wake, then sleep
	task automatic prep(input logic [7:0] msk, input logic [7:0] gcmd);
		wr(rwp_pkg::IX_TIMER_CONTROL_REG, 8'h3e);
		wr(rwp_pkg::IX_CMD, 8'h02);
		wr(rwp_pkg::IX_WDC, 8'h00);
		rd_chk(rwp_pkg::IX_PORT6, {24'h0, p6_drv});
		wr(rwp_pkg::IX_IFLAG, 8'h00);
		wr(rwp_pkg::IX_IMASK, msk);
		wr(rwp_pkg::IX_CMD, gcmd);
		wr(rwp_pkg::IX_CMD, 8'h01);
		settle();
		chk(core_sleep, 1'h1);
		@(posedge clk_sys);
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fail_count++;
			$display("mismatch at %0t: run did not finish", $time);
			wrap_up();
		end
	end

	// ************
	// test sequence
	// ************
	initial
	begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'h1;
		repeat (RC - 2) @(posedge clk_sys);
		#1;
		chk({core_reset, osc_en}, 2'h3);
		chk({p5_oe, p6_oe}, 12'h0);
		repeat (8) @(posedge clk_sys);
		#1;
		chk(core_reset, 1'h0);
		for (int i = 0; i < 8; i++)
			rd_chk(ix_t[i], {24'h0, rv_t[i]});
		wr(rwp_pkg::IX_WDC, 8'h00);
		pins_cfg(8'h00, 8'h00, 8'h00);
		chk({p5_oe, p6_oe}, 12'hff7);
		chk(p6_pu, 8'hf7);
		chk({p5_pd, p6_pd}, 6'h3f);
		wr(rwp_pkg::IX_PORT5, 8'h0a);
		wr(rwp_pkg::IX_PORT6, 8'h5a);
		settle();
		chk({p5_out, p6_out}, 12'ha5a);
		rd_chk(rwp_pkg::IX_PORT5, 32'h0a);
		// open drain: only pins whose data bit is low are driven
		pins_cfg(8'h00, 8'h00, 8'hff);
		chk(p6_oe, 8'ha5);
		pins_cfg(8'hff, 8'hff, 8'h00);
		chk({p5_oe, p6_oe, p6_pu, p5_pd, p6_pd}, 26'h0);
		wr(rwp_pkg::IX_TIMER_CONTROL_REG, 8'h38);
		wr(rwp_pkg::IX_WDC, 8'h80);
		repeat (3)
		begin
			watch(30, s);
			chk(s[3], 1'h0);
			wr(rwp_pkg::IX_CMD, 8'h02);
		end
		watch(4, s);
		chk(s[3], 1'h0);
		wr(rwp_pkg::IX_CMD, 8'h01);
		settle();
		chk({core_sleep, osc_en}, 2'h2);
		rd_chk(rwp_pkg::IX_STATUS, 32'h10);
		watch(WC + 10, s);
		chk(s[3:2], 2'h2);
		repeat (RC + 5) @(posedge clk_sys);
		rd_chk(rwp_pkg::IX_STATUS, 32'h00);
		rd_chk(rwp_pkg::IX_WDC, 32'h80);
		rd_chk(rwp_pkg::IX_TIMER_CONTROL_REG, 32'hbf);
		prep(8'h02, 8'h04);
		p6_drv <= 8'hfe;
		watch(8, s);
		chk(s, 4'h5);
		rd_chk(rwp_pkg::IX_STATUS, 32'h90);
		rd_chk(rwp_pkg::IX_WDC, 32'h80);
		prep(8'h02, 8'h08);
		p6_drv <= 8'hff;
		watch(8, s);
		chk(s, 4'h3);
		// software status bits must survive a pin reset
		wr(rwp_pkg::IX_STATUS, 8'h60);
		prep(8'h01, 8'h04);
		p6_drv <= 8'h7f;
		tick_timer();
		watch(20, s);
		chk(s, 4'h0);
		ext_reset_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		ext_reset_n <= 1'h1;
		watch(RC + 10, s);
		chk(s[3], 1'h1);
		rd_chk(rwp_pkg::IX_STATUS, 32'h70);
		wr(rwp_pkg::IX_WDC, 8'h00);
		wr(rwp_pkg::IX_IMASK, 8'h01);
		wr(rwp_pkg::IX_CMD, 8'h08);
		tick_timer();
		watch(6, s);
		chk(s, 4'h1);
		wr(rwp_pkg::IX_CMD, 8'h04);
		watch(6, s);
		chk(s, 4'h5);
		lvd_det <= 1'h1;
		@(posedge clk_sys);
		lvd_det <= 1'h0;
		watch(4, s);
		chk(s[3], 1'h1);
		repeat (RC + 5) @(posedge clk_sys);
		rd_chk(8'h30, 32'h0);
		chk(hresp, 1'h0);
		wrap_up();
	end
endmodule
